/* File: verilog/sirr_pkg.sv */
// package for the initiator result reporter: codes, steps, reset values, timing, commands
package sirr_pkg;
    localparam logic [7:0] CODE_RESET      = 8'h01;
    localparam logic [7:0] CODE_PAR_DMA    = 8'h21;
    localparam logic [7:0] CODE_PAR_MPU    = 8'h22;
    localparam logic [7:0] CODE_PAR_SCSI   = 8'h24;
    localparam logic [7:0] CODE_PAR_DSCSI  = 8'h25;
    localparam logic [7:0] CODE_PAR_MSCSI  = 8'h26;
    localparam logic [7:0] CODE_OFS_OVR    = 8'h29;
    localparam logic [7:0] CODE_REQ_FAST   = 8'h2a;
    localparam logic [7:0] CODE_OFS_FAST   = 8'h2b;
    localparam logic [7:0] CODE_TIMEOUT    = 8'h2c;
    localparam logic [7:0] CODE_FREE_XFER  = 8'h31;
    localparam logic [7:0] CODE_PHASE_CHG  = 8'h32;
    localparam logic [7:0] CODE_BAD_PHASE  = 8'h54;
    localparam logic [7:0] CODE_BAD_MSG    = 8'h55;
    localparam logic [7:0] CODE_BAD_STAT   = 8'h56;
    localparam logic [7:0] CODE_DONE       = 8'h60;
    localparam logic [7:0] CODE_REG_PAR    = 8'h66;
    localparam logic [7:0] CODE_PAUSE      = 8'h67;
    localparam logic [7:0] CODE_FREE       = 8'h70;

    localparam logic [7:0] STEP_00         = 8'h00;
    localparam logic [7:0] STEP_01         = 8'h01;
    localparam logic [7:0] STEP_02         = 8'h02;
    localparam logic [7:0] STEP_09         = 8'h09;
    localparam logic [7:0] STEP_0A         = 8'h0a;

    localparam logic [7:0] RESET_CODE      = 8'h00;
    localparam logic [7:0] RESET_STEP      = 8'h00;
    localparam int         EXIT_NS         = 200;
    localparam int         CLK_NS          = 25;
    localparam int         EXIT_CYC        = (EXIT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        SIRR_CMD_ATN_SET,
        SIRR_CMD_ATN_CLR,
        SIRR_CMD_ACK_SET,
        SIRR_CMD_ACK_CLR,
        SIRR_CMD_DATA_OUT,
        SIRR_CMD_DATA_IN,
        SIRR_CMD_OTHER
    } sirr_cmd_t;
endpackage : sirr_pkg

/* File: verilog/sirr_exit_timer.sv */
// exit processing delay counter
`timescale 1ns/1ps
`default_nettype none
module sirr_exit_timer #(
    parameter int CYCLES = 8
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // control
    input  wire logic start,
    output logic      done
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        done_q;
    logic        done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start) begin
            cnt_d = CYCLES[15:0];
        end else if (cnt_q != 16'h0000) begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
endmodule // sirr_exit_timer
`default_nettype wire

/* File: verilog/sirr_reporter.sv */
// initiator result reporter: picks code and step for each finished command except SIRR_CMD_OTHER, which gets no report
`timescale 1ns/1ps
`default_nettype none
module sirr_reporter
    import sirr_pkg::*;
#(
    parameter int EXIT_CYCLES = sirr_pkg::EXIT_CYC
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    // command from host
    input  wire logic            cmd_start,
    input  wire sirr_pkg::sirr_cmd_t cmd_kind,
    input  wire logic            prev_was_xfer,
    input  wire logic            dma_path,
    input  wire logic            count_zero,
    // mode configuration
    input  wire logic            auto_ack_release,
    input  wire logic            auto_receive,
    input  wire logic            sync_mode,
    // bus events
    input  wire logic            bus_reset,
    input  wire logic            bus_free,
    input  wire logic            ack_held,
    input  wire logic            phase_change,
    input  wire logic            first_req,
    input  wire logic            first_phase_ok,
    input  wire logic            got_msg_byte,
    input  wire logic            got_stat_byte,
    input  wire logic            xfer_done,
    input  wire logic            cmd_pause,
    // error events
    input  wire logic            par_dma,
    input  wire logic            par_mpu,
    input  wire logic            par_scsi,
    input  wire logic            ofs_overrun,
    input  wire logic            req_too_fast,
    input  wire logic            req_timeout,
    input  wire logic            reg_parity,
    // host result port
    input  wire logic            result_clear,
    output logic [7:0]           result_code,
    output logic [7:0]           result_step,
    output logic                 result_irq,
    output logic                 padding,
    output logic                 atn_out,
    output logic                 busy
);
    import sirr_pkg::*;

    typedef enum logic [2:0] {
        SIRR_IDLE, SIRR_CTRL, SIRR_XFER, SIRR_PAD, SIRR_EXIT, SIRR_HELD
    } sirr_state_t;

    sirr_state_t state_q, state_d;
    sirr_cmd_t   kind_q, kind_d;
    logic [7:0]  code_q, code_d, step_q, step_d;
    logic [7:0]  pcode_q, pcode_d;
    logic        irq_q, irq_d, atn_q, atn_d, started_q, started_d, prevx_q, prevx_d;
    logic        exit_go, exit_done, is_data, fin;
    logic [7:0]  err_code;
    logic        err_hit;

    sirr_exit_timer #(.CYCLES(EXIT_CYCLES)) u_exit (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (exit_go),
        .done    (exit_done)
    );

    assign is_data = (kind_q == SIRR_CMD_DATA_OUT) || (kind_q == SIRR_CMD_DATA_IN);

    // error code selection; timeout only counts in asynchronous mode
    always_comb begin
        err_hit  = 1'b1;
        err_code = CODE_PAR_SCSI;
        if (par_scsi && par_dma && dma_path)             err_code = CODE_PAR_DSCSI;
        else if (par_scsi && par_mpu && !dma_path)       err_code = CODE_PAR_MSCSI;
        else if (par_scsi)                               err_code = CODE_PAR_SCSI;
        else if (par_dma && dma_path)                    err_code = CODE_PAR_DMA;
        else if (par_mpu && !dma_path)                   err_code = CODE_PAR_MPU;
        else if (sync_mode && ofs_overrun && req_too_fast) err_code = CODE_OFS_FAST;
        else if (sync_mode && ofs_overrun)               err_code = CODE_OFS_OVR;
        else if (req_too_fast)                           err_code = CODE_REQ_FAST;
        else                                             err_hit  = 1'b0;
    end

    always_comb begin
        state_d   = state_q;
        kind_d    = kind_q;
        code_d    = code_q;
        step_d    = step_q;
        pcode_d   = pcode_q;
        irq_d     = irq_q;
        atn_d     = atn_q;
        started_d = started_q;
        prevx_d   = prevx_q;
        exit_go   = 1'b0;
        fin       = 1'b0;
        if (result_clear) begin
            irq_d = 1'b0;
        end
        case (state_q)
            SIRR_IDLE: begin
                if (reg_parity) begin
                    code_d = CODE_REG_PAR; step_d = STEP_00; fin = 1'b1;
                end else if (cmd_start) begin
                    kind_d    = cmd_kind;
                    prevx_d   = prev_was_xfer;
                    started_d = 1'b0;
                    if (cmd_kind == SIRR_CMD_DATA_OUT || cmd_kind == SIRR_CMD_DATA_IN) begin
                        // zero count skips straight to padding, no 65h
                        state_d = count_zero ? SIRR_PAD : SIRR_XFER;
                        started_d = count_zero;
                    end else if (cmd_kind != SIRR_CMD_OTHER) begin
                        state_d = SIRR_CTRL;
                    end
                end
            end
            SIRR_CTRL: begin
                if (bus_reset) begin
                    code_d = CODE_RESET; step_d = STEP_00; fin = 1'b1;
                end else if (bus_free && prevx_q) begin
                    // only manual mode leaves ack held for this case
                    if (!auto_ack_release) begin
                        code_d = CODE_FREE_XFER; step_d = STEP_00; fin = 1'b1;
                    end else begin
                        code_d = CODE_FREE; step_d = STEP_00; fin = 1'b1;
                    end
                end else if (bus_free) begin
                    code_d = CODE_FREE; step_d = STEP_00; fin = 1'b1;
                end else begin
                    code_d = CODE_DONE;
                    step_d = (auto_ack_release && kind_q == SIRR_CMD_ATN_SET) ? STEP_09 : STEP_01;
                    fin    = 1'b1;
                end
            end
            SIRR_XFER: begin
                if (bus_reset) begin
                    code_d = CODE_RESET; step_d = started_q ? STEP_01 : STEP_00; fin = 1'b1;
                end else if (bus_free && !started_q) begin
                    code_d = CODE_FREE; step_d = STEP_01; fin = 1'b1;
                end else if (first_req && !started_q && !first_phase_ok) begin
                    code_d = auto_receive && got_msg_byte  ? CODE_BAD_MSG :
                             auto_receive && got_stat_byte ? CODE_BAD_STAT :
                             CODE_BAD_PHASE;
                    step_d = STEP_01;
                    fin    = 1'b1;
                end else if (err_hit) begin
                    atn_d   = 1'b1;
                    pcode_d = err_code;
                    step_d  = auto_ack_release ? STEP_09 : STEP_01;
                    state_d = SIRR_PAD;
                end else if (req_timeout && !sync_mode) begin
                    pcode_d = CODE_TIMEOUT; step_d = STEP_01; state_d = SIRR_EXIT; exit_go = 1'b1;
                end else if (bus_free) begin
                    pcode_d = CODE_FREE_XFER; step_d = STEP_01; state_d = SIRR_EXIT; exit_go = 1'b1;
                end else if (phase_change) begin
                    pcode_d = CODE_PHASE_CHG; step_d = STEP_01; state_d = SIRR_EXIT; exit_go = 1'b1;
                end else if (cmd_pause) begin
                    pcode_d = CODE_PAUSE; step_d = STEP_01; state_d = SIRR_EXIT; exit_go = 1'b1;
                end else if (xfer_done) begin
                    pcode_d = CODE_DONE; step_d = STEP_02; state_d = SIRR_PAD;
                end else if (first_req) begin
                    started_d = 1'b1;
                end
            end
            SIRR_PAD: begin
                // padding runs until the target leaves the data phase
                if (bus_reset) begin
                    code_d = CODE_RESET; step_d = STEP_02; fin = 1'b1;
                end else if (bus_free) begin
                    code_d = CODE_FREE; step_d = STEP_02; fin = 1'b1;
                end else if (phase_change || xfer_done) begin
                    code_d = (pcode_q == 8'h00) ? CODE_DONE : pcode_q;
                    if (pcode_q == 8'h00 || pcode_q == CODE_DONE) begin
                        step_d = auto_ack_release ? STEP_0A : STEP_02;
                    end else begin
                        step_d = step_q;
                    end
                    fin = 1'b1;
                end
            end
            SIRR_EXIT: begin
                if (bus_reset) begin
                    code_d = CODE_RESET; step_d = STEP_01; fin = 1'b1;
                end else if (exit_done) begin
                    code_d = pcode_q; fin = 1'b1;
                end
            end
            SIRR_HELD: begin
                if (bus_free) begin
                    code_d = CODE_FREE_XFER; step_d = STEP_00; fin = 1'b1;
                end else if (cmd_start || bus_reset) begin
                    state_d = SIRR_IDLE;
                end
            end
            default: state_d = SIRR_IDLE;
        endcase
        if (fin) begin
            irq_d   = 1'b1;
            atn_d   = 1'b0;
            pcode_d = 8'h00;
            state_d = (is_data && !auto_ack_release && ack_held && !bus_free) ? SIRR_HELD : SIRR_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= SIRR_IDLE;
            kind_q    <= SIRR_CMD_OTHER;
            code_q    <= RESET_CODE;
            step_q    <= RESET_STEP;
            pcode_q   <= 8'h00;
            irq_q     <= 1'b0;
            atn_q     <= 1'b0;
            started_q <= 1'b0;
            prevx_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            kind_q    <= kind_d;
            code_q    <= code_d;
            step_q    <= step_d;
            pcode_q   <= pcode_d;
            irq_q     <= irq_d;
            atn_q     <= atn_d;
            started_q <= started_d;
            prevx_q   <= prevx_d;
        end
    end

    assign result_code = code_q;
    assign result_step = step_q;
    assign result_irq  = irq_q;
    assign atn_out     = atn_q;
    assign padding     = (state_q == SIRR_PAD);
    assign busy        = (state_q != SIRR_IDLE) && (state_q != SIRR_HELD);

    reset_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_XFER && bus_reset && !started_q) |=> (code_q == 8'h01 && step_q == 8'h00 && irq_q))
        else $error("reset before transfer wrong step");
    ctrl_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_CTRL && !bus_reset && !bus_free && !auto_ack_release) |=> (code_q == 8'h60 && step_q == 8'h01))
        else $error("control command normal end wrong");
    atn_err_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_XFER && !bus_reset && started_q && !bus_free && err_hit) |=> atn_q)
        else $error("atn not asserted on error");
    free_pad_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_PAD && !bus_reset && bus_free) |=> (code_q == 8'h70 && step_q == 8'h02))
        else $error("bus free in padding wrong");
    zero_pad_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_IDLE && !reg_parity && cmd_start && count_zero
         && (cmd_kind == SIRR_CMD_DATA_IN || cmd_kind == SIRR_CMD_DATA_OUT)) |=> padding)
        else $error("zero count did not pad");
    reg_par_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_IDLE && reg_parity) |=> (code_q == 8'h66 && step_q == 8'h00 && irq_q))
        else $error("register parity report wrong");
    exit_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(state_q == SIRR_EXIT) |-> !irq_q[*2])
        else $error("report raised before exit processing");
    clr_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (result_clear && !fin) |=> !irq_q)
        else $error("clear did not drop request");
    free_ctrl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == SIRR_CTRL && !bus_reset && bus_free && !prevx_q) |=> (code_q == 8'h70 && step_q == 8'h00))
        else $error("bus free before control cmd wrong");
    cov_done_c:  cover property (@(posedge sys_clk) state_q == SIRR_PAD ##1 (irq_q && code_q == 8'h60));
    cov_err_c:   cover property (@(posedge sys_clk) atn_q ##[1:20] irq_q);
    cov_exit_c:  cover property (@(posedge sys_clk) state_q == SIRR_EXIT ##[1:20] state_q == SIRR_IDLE);
endmodule // sirr_reporter
`default_nettype wire

/* File: verification/sirr_target_model.sv */
// behavioural scsi target: first req of a data phase, then end of transfer
`timescale 1ns/1ps
`default_nettype none
module sirr_target_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // from the bench
    input  wire logic go,
    input  wire logic slow,
    input  wire logic wrong_phase,
    input  wire logic stall,
    input  wire logic quit,
    // toward the reporter
    output var  logic first_req,
    output var  logic first_phase_ok,
    output var  logic xfer_done
);
    logic       act_q;
    logic [4:0] cnt_q;
    logic [4:0] req_at;

    // slow target leaves more room before its first req
    assign req_at = slow ? 5'h06 : 5'h03;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_q          <= 1'b0;
            cnt_q          <= 5'h00;
            first_req      <= 1'b0;
            first_phase_ok <= 1'b0;
            xfer_done      <= 1'b0;
        end else begin
            first_req <= act_q && (cnt_q == req_at);
            // stalled target never ends the transfer on its own;
            // second pulse marks the target leaving the data phase, which ends padding
            xfer_done <= act_q && !stall && ((cnt_q == req_at + 5'h08) || (cnt_q == req_at + 5'h0a));
            // phase is only meaningful with req; flip it elsewhere so stale values never match
            first_phase_ok <= (act_q && cnt_q == req_at) ? !wrong_phase : !first_phase_ok;
            cnt_q <= go ? 5'h00 : cnt_q + 5'h01;
            if (go) begin
                act_q <= 1'b1;
            end else if (quit) begin
                act_q <= 1'b0;
            end
        end
    end
endmodule // sirr_target_model
`default_nettype wire

/* File: verification/tb_sirr_reporter.sv */
// self-checking bench for the initiator result reporter
`timescale 1ns/1ps
`default_nettype none
module tb_sirr_reporter;
    import sirr_pkg::*;
    logic       sys_clk, sys_rst, cmd_start, prev_was_xfer, dma_path, count_zero;
    logic       auto_ack_release, auto_receive, sync_mode, ack_held, reg_parity, result_clear;
    logic       first_req, first_phase_ok, xfer_done, wrong_phase, stall, k_sel;
    logic [9:0] ev;
    logic [1:0] lv;
    logic [7:0] result_code, result_step;
    logic       result_irq, padding, atn_out, busy;
    sirr_cmd_t  cmd_kind;
    int         miscompares, checks_done;

    sirr_reporter #(.EXIT_CYCLES(2)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
        .prev_was_xfer(prev_was_xfer), .dma_path(dma_path), .count_zero(count_zero),
        .auto_ack_release(auto_ack_release), .auto_receive(auto_receive), .sync_mode(sync_mode),
        .bus_reset(ev[6]), .bus_free(ev[7]), .ack_held(ack_held), .phase_change(ev[8]),
        .first_req(first_req), .first_phase_ok(first_phase_ok), .got_msg_byte(lv[0]),
        .got_stat_byte(lv[1]), .xfer_done(xfer_done), .cmd_pause(ev[9]), .par_dma(ev[0]),
        .par_mpu(ev[1]), .par_scsi(ev[2]), .ofs_overrun(ev[3]), .req_too_fast(ev[4]),
        .req_timeout(ev[5]), .reg_parity(reg_parity), .result_clear(result_clear),
        .result_code(result_code), .result_step(result_step), .result_irq(result_irq),
        .padding(padding), .atn_out(atn_out), .busy(busy)
    );

    sirr_target_model u_tgt (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .go(cmd_start && (cmd_kind inside {SIRR_CMD_DATA_OUT, SIRR_CMD_DATA_IN})),
        .slow(k_sel), .wrong_phase(wrong_phase), .stall(stall), .quit(result_irq),
        .first_req(first_req), .first_phase_ok(first_phase_ok), .xfer_done(xfer_done)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // host side reads the report, then clears it before the next command
    task automatic wait_irq(input logic [7:0] c, input logic [7:0] s);
        for (int i = 0; i < 100 && result_irq !== 1'b1; i++) tick();
        if (result_irq !== 1'b1) begin
            miscompares++;
            results();
        end
        chk("code", result_code, c);
        chk("step", result_step, s);
        result_clear = 1'b1;
        tick();
        result_clear = 1'b0;
        tick();
    endtask

    task automatic start(input sirr_cmd_t k);
        cmd_kind = k;
        cmd_start = 1'b1;
        tick();
        cmd_start = 1'b0;
    endtask

    // control command; m = {bus free, bus reset} seen in the deciding cycle
    task automatic ccase(input sirr_cmd_t k, input logic p, input logic a, input logic [1:0] m,
                         input logic [7:0] c, input logic [7:0] s);
        prev_was_xfer = p;
        auto_ack_release = a;
        start(k);
        ev[7:6] = m;
        tick();
        ev = '0;
        wait_irq(c, s);
    endtask

    // data command; f = {auto rx, wrong phase, zero count, early, dma, sync, auto ack}
    task automatic dcase(input logic [6:0] f, input logic [11:0] m, input logic [7:0] c, input logic [7:0] s);
        {auto_receive, wrong_phase, count_zero} = f[6:4];
        {dma_path, sync_mode, auto_ack_release} = f[2:0];
        lv = m[11:10];
        stall = (m[9:0] != 10'h000) || f[5];
        k_sel = ~k_sel;
        start(k_sel ? SIRR_CMD_DATA_IN : SIRR_CMD_DATA_OUT);
        repeat (f[3] ? 0 : 8) tick();
        if (f[4]) chk("padding", {7'h00, padding}, 8'h01);
        ev = m[9:0];
        tick();
        ev = '0;
        // data errors park the transfer in padding until the target moves on
        if (m[4:0] != 5'h00) begin
            tick();
            chk("atn", {7'h00, atn_out}, 8'h01);
            ev[8] = 1'b1;
            tick();
            ev[8] = 1'b0;
        end
        wait_irq(c, s);
        lv = 2'b00;
    endtask

    initial begin
        {cmd_start, prev_was_xfer, dma_path, count_zero, auto_ack_release, auto_receive} = 6'h00;
        {sync_mode, ack_held, reg_parity, result_clear, wrong_phase, stall, k_sel} = 7'h00;
        ev = '0;
        lv = 2'b00;
        cmd_kind = SIRR_CMD_ATN_SET;
        miscompares = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        repeat (5) tick();
        chk("reset code", result_code, 8'h00);
        chk("reset irq", {6'h00, result_irq, busy}, 8'h00);
        sys_rst = 1'b0;
        tick();
        for (int i = 0; i < 4; i++) ccase(sirr_cmd_t'(i), 1'b0, 1'b0, 2'b00, CODE_DONE, STEP_01);
        ccase(SIRR_CMD_ATN_SET, 1'b0, 1'b1, 2'b00, CODE_DONE, STEP_09);
        ccase(SIRR_CMD_ATN_CLR, 1'b0, 1'b1, 2'b00, CODE_DONE, STEP_01);
        ccase(SIRR_CMD_ACK_SET, 1'b0, 1'b0, 2'b01, CODE_RESET, STEP_00);
        ccase(SIRR_CMD_ACK_CLR, 1'b1, 1'b0, 2'b10, CODE_FREE_XFER, STEP_00);
        ccase(SIRR_CMD_ATN_SET, 1'b0, 1'b0, 2'b10, CODE_FREE, STEP_00);
        dcase(7'h00, 12'h000, CODE_DONE, STEP_02);
        dcase(7'h01, 12'h000, CODE_DONE, STEP_0A);
        dcase(7'h10, 12'h000, CODE_DONE, STEP_02);
        dcase(7'h04, 12'h001, CODE_PAR_DMA, STEP_01);
        dcase(7'h00, 12'h002, CODE_PAR_MPU, STEP_01);
        dcase(7'h00, 12'h004, CODE_PAR_SCSI, STEP_01);
        dcase(7'h04, 12'h005, CODE_PAR_DSCSI, STEP_01);
        dcase(7'h00, 12'h006, CODE_PAR_MSCSI, STEP_01);
        dcase(7'h01, 12'h004, CODE_PAR_SCSI, STEP_09);
        dcase(7'h02, 12'h008, CODE_OFS_OVR, STEP_01);
        dcase(7'h00, 12'h010, CODE_REQ_FAST, STEP_01);
        dcase(7'h02, 12'h018, CODE_OFS_FAST, STEP_01);
        dcase(7'h00, 12'h020, CODE_TIMEOUT, STEP_01);
        dcase(7'h00, 12'h080, CODE_FREE_XFER, STEP_01);
        dcase(7'h00, 12'h100, CODE_PHASE_CHG, STEP_01);
        dcase(7'h00, 12'h200, CODE_PAUSE, STEP_01);
        dcase(7'h00, 12'h040, CODE_RESET, STEP_01);
        dcase(7'h08, 12'h040, CODE_RESET, STEP_00);
        dcase(7'h10, 12'h040, CODE_RESET, STEP_02);
        dcase(7'h48, 12'h080, CODE_FREE, STEP_01);
        dcase(7'h10, 12'h080, CODE_FREE, STEP_02);
        dcase(7'h20, 12'h000, CODE_BAD_PHASE, STEP_01);
        dcase(7'h60, 12'h400, CODE_BAD_MSG, STEP_01);
        dcase(7'h60, 12'h800, CODE_BAD_STAT, STEP_01);
        ack_held = 1'b1;
        dcase(7'h00, 12'h000, CODE_DONE, STEP_02);
        ev[7] = 1'b1;
        tick();
        ev[7] = 1'b0;
        wait_irq(CODE_FREE_XFER, STEP_00);
        ack_held = 1'b0;
        reg_parity = 1'b1;
        tick();
        reg_parity = 1'b0;
        wait_irq(CODE_REG_PAR, STEP_00);
        results();
    end
endmodule // tb_sirr_reporter
`default_nettype wire
